// ### inc/sleep_rail_regs.vh
`ifndef SLEEP_RAIL_REGS_VH
`define SLEEP_RAIL_REGS_VH
`define CLK_HZ            40000000
`define ACK_TIMEOUT_S     4
`define ACK_TIMEOUT_CYC   (`ACK_TIMEOUT_S * `CLK_HZ)
`define PWR_CYCLE_MS      4
`define PWR_CYCLE_CYC     (`PWR_CYCLE_MS * (`CLK_HZ / 1000))
`define PLATFORM_RESET_N_HOLD_MS    1
`define PLATFORM_RESET_N_HOLD_CYC   (`PLATFORM_RESET_N_HOLD_MS * (`CLK_HZ / 1000))
`define ACK_POLICY_DLY    16'h0010
`define RST_NONE          2'h0
`define RST_HOST          2'h1
`define RST_HOST_PC       2'h2
`define RST_GLOBAL        2'h3
`define RTC_CFG_RESET     4'h0
`endif

// ### hdl/sync2.v
`timescale 1ns/1ps
// Two-stage synchroniser for a bus of asynchronous levels.
module sync2 #(
	parameter W = 1
) (
	input  wire         clk_i,
	input  wire [W-1:0] d_i,
	output wire [W-1:0] q_o
);
	reg [W-1:0] meta_r;
	reg [W-1:0] sync_r;

	// The first stage feeds only the second stage.
	always @(posedge clk_i) begin
		meta_r <= d_i;
		sync_r <= meta_r;
	end

	assign q_o = sync_r;
endmodule // sync2

// ### hdl/sleep_rail_ctl.v
`timescale 1ns/1ps
`include "sleep_rail_regs.vh"
module sleep_rail_ctl #(
	parameter [31:0] ACK_TIMEOUT_CYC = `ACK_TIMEOUT_CYC,
	parameter [31:0] PWR_CYCLE_CYC   = `PWR_CYCLE_CYC,
	parameter [31:0] PLATFORM_RESET_N_HOLD_CYC = `PLATFORM_RESET_N_HOLD_CYC
) (
	// Clock and reset.
	input  wire       core_clk_i,
	input  wire       srst_i,
	// Asynchronous pins.
	input  wire       battery_low_n_i,
	input  wire       rtc_well_reset_n_i,
	input  wire       secure_rtc_reset_n_i,
	input  wire       on_battery_i,
	input  wire       wake_event_i,
	// Sleep state requests from the power-state logic.
	input  wire       s3_req_i,
	input  wire       s4_req_i,
	input  wire       s5_req_i,
	input  wire       mgmt_off_req_i,
	input  wire       c10_entry_i,
	// RTC-well settings, loaded by the load strobe.
	input  wire       cfg_load_i,
	input  wire       after_g3_phy_power_en_i,
	input  wire       sleep_phy_power_en_i,
	input  wire       battery_phy_power_dis_i,
	input  wire       host_wireless_power_en_i,
	// Management power policy.
	input  wire       mgmt_wlan_access_i,
	input  wire       mgmt_lan_keep_i,
	input  wire       mgmt_ack_policy_i,
	input  wire       s5_pin_is_gpio_i,
	input  wire       lan_pin_is_gpio_i,
	// Reset requests and memory handshake.
	input  wire [1:0] reset_req_i,
	input  wire       s5_reset_req_i,
	input  wire       mem_safe_i,
	input  wire       reset_ack_i,
	// Rail, sleep and reset outputs.
	output reg        sleep_s3_ctl_n_o,
	output reg        sleep_s4_ctl_n_o,
	output reg        sleep_s5_ctl_n_o,
	output reg        mgmt_sleep_ctl_n_o,
	output reg        wired_phy_rail_ctl_n_o,
	output reg        wireless_phy_rail_ctl_n_o,
	output reg        primary_powerdown_ack_o,
	output reg        deep_idle_gate_n_o,
	output reg        platform_reset_n_o,
	output reg        mem_drain_req_o,
	output reg        smi_o,
	output reg        mgmt_bb_reset_o,
	output reg        global_reset_o,
	output reg        g3_seen_o
);
	// Sequencer states, one-hot.
	localparam [6:0] ST_RUN   = 7'h01;
	localparam [6:0] ST_DRAIN = 7'h02;
	localparam [6:0] ST_PLTRS = 7'h04;
	localparam [6:0] ST_WACK  = 7'h08;
	localparam [6:0] ST_PWRDN = 7'h10;
	localparam [6:0] ST_S5    = 7'h20;
	localparam [6:0] ST_SLEEP = 7'h40;

	wire [4:0] pin_s;
	wire       battery_low_n_s;
	wire       rtc_well_reset_n_s;
	wire       secure_rtc_reset_n_s;
	wire       on_batt_s;
	wire       wake_s;

	sync2 #(.W(5)) u_sync (
		.clk_i (core_clk_i),
		.d_i   ({battery_low_n_i, rtc_well_reset_n_i, secure_rtc_reset_n_i,
		         on_battery_i, wake_event_i}),
		.q_o   (pin_s)
	);
	assign battery_low_n_s  = ~pin_s[4];
	assign rtc_well_reset_n_s  = ~pin_s[3];
	assign secure_rtc_reset_n_s = ~pin_s[2];
	assign on_batt_s = pin_s[1];
	assign wake_s    = pin_s[0];

	reg [6:0]  state_r;
	reg [6:0]  state_nxt;
	reg [31:0] cnt_r;
	reg [1:0]  kind_r;
	reg        kind_s5_r;
	reg [15:0] pol_cnt_r;
	reg [3:0]  rtc_cfg_r;
	reg        battery_low_n_d_r;

	// RTC-well settings; RTC reset restores defaults, not the core reset.
	always @(posedge core_clk_i) begin
		if (rtc_well_reset_n_s) begin
			rtc_cfg_r <= `RTC_CFG_RESET;
		end else if (cfg_load_i) begin
			rtc_cfg_r <= {after_g3_phy_power_en_i, sleep_phy_power_en_i,
			              battery_phy_power_dis_i, host_wireless_power_en_i};
		end
	end

	// G3 marker and battery-backed management reset, kept across global resets.
	always @(posedge core_clk_i) begin
		mgmt_bb_reset_o <= secure_rtc_reset_n_s & rtc_well_reset_n_s;
		if (rtc_well_reset_n_s) begin
			g3_seen_o <= 1'b1;
		end else if (state_r == ST_RUN && s3_req_i == 1'b0) begin
			g3_seen_o <= 1'b0;
		end
	end

	wire in_s0    = (state_r == ST_RUN) & ~s3_req_i;
	wire deep_sx  = (state_r == ST_SLEEP) & (s4_req_i | s5_req_i);
	wire trig_any = (reset_req_i != `RST_NONE) | s5_reset_req_i;

	// Next state of the reset and sleep sequencer.
	always @* begin
		state_nxt = state_r;
		case (state_r)
			ST_RUN: begin
				if (trig_any) begin
					state_nxt = ST_DRAIN;
				end else if (s3_req_i) begin
					state_nxt = ST_SLEEP;
				end
			end
			ST_SLEEP: begin
				if (trig_any) begin
					state_nxt = ST_DRAIN;
				end else if (wake_s && !(battery_low_n_s && deep_sx)) begin
					state_nxt = ST_RUN;
				end
			end
			ST_DRAIN: begin
				if (mem_safe_i) begin
					state_nxt = kind_s5_r ? ST_S5 : ST_PLTRS;
				end
			end
			ST_PLTRS: begin
				if (cnt_r >= PLATFORM_RESET_N_HOLD_CYC - 32'd1) begin
					state_nxt = (kind_r == `RST_HOST) ? ST_WACK : ST_PWRDN;
				end
			end
			ST_WACK: begin
				if (reset_ack_i) begin
					state_nxt = ST_RUN;
				end else if (cnt_r >= ACK_TIMEOUT_CYC - 32'd1) begin
					state_nxt = ST_PWRDN;
				end
			end
			ST_PWRDN: begin
				if (cnt_r >= PWR_CYCLE_CYC - 32'd1) begin
					state_nxt = ST_RUN;
				end
			end
			ST_S5: begin
				if (wake_s && !battery_low_n_s) begin
					state_nxt = ST_RUN;
				end
			end
			default: begin
				state_nxt = ST_RUN;
			end
		endcase
	end

	// Sequencer registers, trigger capture and phase counter.
	always @(posedge core_clk_i) begin
		if (srst_i) begin
			state_r   <= ST_RUN;
			cnt_r     <= 32'h0000_0000;
			kind_r    <= `RST_NONE;
			kind_s5_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			cnt_r   <= (state_nxt != state_r) ? 32'h0000_0000 : cnt_r + 32'd1;
			if ((state_r == ST_RUN || state_r == ST_SLEEP) && trig_any) begin
				kind_s5_r <= s5_reset_req_i;
				kind_r    <= s5_reset_req_i ? `RST_NONE : reset_req_i;
			end else if (state_r == ST_WACK && state_nxt == ST_PWRDN) begin
				kind_r <= `RST_GLOBAL;
			end
		end
	end

	// Delay before the straight-to-S5 ack follows the management policy.
	always @(posedge core_clk_i) begin
		if (srst_i || state_r != ST_S5) begin
			pol_cnt_r <= 16'h0000;
		end else if (pol_cnt_r != `ACK_POLICY_DLY) begin
			pol_cnt_r <= pol_cnt_r + 16'h0001;
		end
	end

	// Battery-low edge in S0 raises a one-cycle SMI.
	always @(posedge core_clk_i) begin
		if (srst_i) begin
			battery_low_n_d_r <= 1'b0;
			smi_o      <= 1'b0;
		end else begin
			battery_low_n_d_r <= battery_low_n_s;
			smi_o      <= battery_low_n_s & ~battery_low_n_d_r & in_s0;
		end
	end

	wire pwr_cut   = (state_r == ST_PWRDN) | (state_r == ST_S5);
	wire in_platform_reset_n = (state_r == ST_PLTRS) | (state_r == ST_WACK) | pwr_cut;
	wire s3_on     = ~pwr_cut & ~s3_req_i & (state_r != ST_SLEEP);
	wire s4_on     = ~pwr_cut & ~(state_r == ST_SLEEP && (s4_req_i | s5_req_i));
	wire s5_on     = ~(state_r == ST_S5 && !s5_pin_is_gpio_i) & ~(state_r == ST_PWRDN)
	                 & ~(state_r == ST_SLEEP && s5_req_i);
	wire mgmt_on   = ~pwr_cut & ~mgmt_off_req_i;
	wire lan_keep  = ((rtc_cfg_r[3] & g3_seen_o) | (rtc_cfg_r[2] & ~g3_seen_o)
	                 | mgmt_lan_keep_i) & ~(rtc_cfg_r[1] & on_batt_s);
	wire lan_on    = s3_on | mgmt_on | (lan_keep & (state_r == ST_SLEEP));
	wire lan_cut   = (state_r == ST_S5) & ~lan_pin_is_gpio_i;
	wire wlan_on   = s3_on | (mgmt_wlan_access_i & mgmt_on)
	                 | (rtc_cfg_r[0] & deep_sx);

	// Registered output pins; platform reset forces the deep idle gate to its reset value.
	always @(posedge core_clk_i) begin
		if (srst_i) begin
			sleep_s3_ctl_n_o          <= 1'b0;
			sleep_s4_ctl_n_o          <= 1'b0;
			sleep_s5_ctl_n_o          <= 1'b0;
			mgmt_sleep_ctl_n_o        <= 1'b0;
			wired_phy_rail_ctl_n_o    <= 1'b0;
			wireless_phy_rail_ctl_n_o <= 1'b0;
			primary_powerdown_ack_o   <= 1'b0;
			deep_idle_gate_n_o        <= 1'b1;
			platform_reset_n_o        <= 1'b0;
			mem_drain_req_o           <= 1'b0;
			global_reset_o            <= 1'b0;
		end else begin
			sleep_s3_ctl_n_o          <= s3_on;
			sleep_s4_ctl_n_o          <= s4_on;
			sleep_s5_ctl_n_o          <= s5_on;
			mgmt_sleep_ctl_n_o        <= mgmt_on;
			wired_phy_rail_ctl_n_o    <= lan_on & ~lan_cut & ~(state_r == ST_PWRDN);
			wireless_phy_rail_ctl_n_o <= wlan_on;
			platform_reset_n_o        <= ~in_platform_reset_n;
			mem_drain_req_o           <= (state_nxt == ST_DRAIN);
			global_reset_o            <= (state_r == ST_PWRDN) & (kind_r == `RST_GLOBAL);
			if (in_platform_reset_n) begin
				deep_idle_gate_n_o <= 1'b1;
			end else begin
				deep_idle_gate_n_o <= ~c10_entry_i;
			end
			if (state_r == ST_S5 && pol_cnt_r == `ACK_POLICY_DLY) begin
				primary_powerdown_ack_o <= mgmt_ack_policy_i;
			end else begin
				primary_powerdown_ack_o <= 1'b0;
			end
		end
	end
endmodule // sleep_rail_ctl

// ### dv/reset_glue_model.sv
`timescale 1ns/1ps
module reset_glue_model (
	// Handshake with the sequencer.
	input  wire clk_i,
	input  wire drain_i,
	input  wire prst_n_i,
	input  wire ack_en_i,
	output reg  mem_safe_o,
	output reg  ack_o
);
	reg [3:0] low_r = 4'h0;
	// Memory is safe a cycle after the drain request.
	// The ack comes late in platform reset, so the wait path is exercised.
	always @(posedge clk_i) begin
		mem_safe_o <= drain_i;
		low_r      <= (prst_n_i !== 1'h0) ? 4'h0 : low_r + 4'h1;
		ack_o      <= ack_en_i && low_r == 4'h9;
	end
endmodule // reset_glue_model

// ### dv/sleep_rail_ctl_chk.sv
`timescale 1ns/1ps
module sleep_rail_ctl_chk (
	input wire core_clk_i,
	input wire srst_i,
	input wire mem_safe_i,
	input wire mgmt_wlan_access_i,
	input wire sleep_s3_ctl_n_o,
	input wire mgmt_sleep_ctl_n_o,
	input wire wired_phy_rail_ctl_n_o,
	input wire wireless_phy_rail_ctl_n_o,
	input wire primary_powerdown_ack_o,
	input wire deep_idle_gate_n_o,
	input wire platform_reset_n_o,
	input wire smi_o,
	input wire global_reset_o
);
	// One clock domain; nothing is judged while reset is applied.
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (srst_i);
	// Rails, reset order and pulse shapes.
	s3_wired_a: assert property (sleep_s3_ctl_n_o |-> wired_phy_rail_ctl_n_o)
		else $error("wired rail off in S0");
	mgmt_wired_a: assert property (mgmt_sleep_ctl_n_o |-> wired_phy_rail_ctl_n_o)
		else $error("wired rail off with mgmt up");
	s3_wlan_a: assert property (sleep_s3_ctl_n_o |-> wireless_phy_rail_ctl_n_o)
		else $error("wireless rail off in S0");
	mgmt_wlan_a: assert property (mgmt_wlan_access_i && $past(mgmt_wlan_access_i)
		&& mgmt_sleep_ctl_n_o |-> wireless_phy_rail_ctl_n_o) else $error("wireless rail off");
	drain_first_a: assert property ($fell(platform_reset_n_o) |-> $past(mem_safe_i))
		else $error("platform reset before memory safe");
	reset_out_a: assert property (!platform_reset_n_o |-> deep_idle_gate_n_o && !smi_o)
		else $error("outputs not in reset state");
	smi_pulse_a: assert property (smi_o |=> !smi_o)
		else $error("interrupt pulse too long");
	glob_ack_a: assert property (global_reset_o [*2] |-> !primary_powerdown_ack_o)
		else $error("powerdown ack high in global reset");
	// Main scenarios reached.
	cover property ($rose(global_reset_o));
	cover property ($fell(platform_reset_n_o));
	cover property (smi_o);
endmodule // sleep_rail_ctl_chk
bind sleep_rail_ctl sleep_rail_ctl_chk i_sleep_rail_ctl_chk (.*);

// ### dv/sleep_rail_ctl_tb.sv
`timescale 1ns/1ps
module sleep_rail_ctl_tb;
	// Design inputs, defined from time zero.
	reg core_clk_i = 1'h0, srst_i = 1'h1, battery_low_n_i = 1'h1, on_battery_i = 1'h0;
	reg rtc_well_reset_n_i = 1'h1, secure_rtc_reset_n_i = 1'h1, wake_event_i = 1'h0;
	reg s3_req_i = 1'h0, s4_req_i = 1'h0, s5_req_i = 1'h0, mgmt_off_req_i = 1'h0;
	reg c10_entry_i = 1'h0, cfg_load_i = 1'h0, s5_reset_req_i = 1'h0, ack_en = 1'h1;
	reg after_g3_phy_power_en_i = 1'h0, sleep_phy_power_en_i = 1'h0;
	reg battery_phy_power_dis_i = 1'h0, host_wireless_power_en_i = 1'h0;
	reg mgmt_wlan_access_i = 1'h1, mgmt_lan_keep_i = 1'h0, mgmt_ack_policy_i = 1'h1;
	reg s5_pin_is_gpio_i = 1'h0, lan_pin_is_gpio_i = 1'h0;
	reg [1:0] reset_req_i = 2'h0;
	reg [3:0] seen;
	integer n_errors = 0, checks_done = 0, i;
	// Design outputs, glue answers and short aliases.
	wire mem_safe_i, reset_ack_i, sleep_s3_ctl_n_o, sleep_s4_ctl_n_o, sleep_s5_ctl_n_o;
	wire mgmt_sleep_ctl_n_o, wired_phy_rail_ctl_n_o, wireless_phy_rail_ctl_n_o, smi_o;
	wire primary_powerdown_ack_o, deep_idle_gate_n_o, platform_reset_n_o, mem_drain_req_o;
	wire mgmt_bb_reset_o, global_reset_o, g3_seen_o, pdk = primary_powerdown_ack_o;
	wire s3n = sleep_s3_ctl_n_o, s4n = sleep_s4_ctl_n_o, s5n = sleep_s5_ctl_n_o;
	wire lan = wired_phy_rail_ctl_n_o, wlan = wireless_phy_rail_ctl_n_o;
	wire man = mgmt_sleep_ctl_n_o, prn = platform_reset_n_o;
	sleep_rail_ctl #(.ACK_TIMEOUT_CYC(32'h0000_0032), .PWR_CYCLE_CYC(32'h0000_0014),
		.PLATFORM_RESET_N_HOLD_CYC(32'h0000_0005)) i_sleep_rail_ctl (.*);
	reset_glue_model i_reset_glue_model (.clk_i(core_clk_i), .drain_i(mem_drain_req_o),
		.prst_n_i(prn), .ack_en_i(ack_en), .mem_safe_o(mem_safe_i), .ack_o(reset_ack_i));
	always #12.5 core_clk_i = ~core_clk_i;
	// Step clock edges and settle just after the last one.
	task cy(input integer n);
		repeat (n) @(posedge core_clk_i);
		#1;
	endtask
	// Compare, count and report.
	task chk(input [7:0] got, input [7:0] exp);
		checks_done = checks_done + 1;
		if (got !== exp) begin
			n_errors = n_errors + 1;
			$display("BAD %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// Load the battery-backed rail settings.
	task ld(input [3:0] v);
		{after_g3_phy_power_en_i, sleep_phy_power_en_i, battery_phy_power_dis_i,
			host_wireless_power_en_i} = v;
		cfg_load_i = 1'h1;
		cy(1);
		cfg_load_i = 1'h0;
		cy(3);
	endtask
	// Sleep states, rail keep settings, RTC reset and blocked wake.
	task t_sleep;
		ld(4'h5);
		{s3_req_i, s4_req_i, s5_req_i, mgmt_off_req_i} = 4'h8;
		cy(4);
		chk({s3n, lan, wlan}, 3'h3);
		{s3_req_i, s4_req_i, s5_req_i, mgmt_off_req_i} = 4'hf;
		cy(4);
		chk({s4n, man, lan, wlan}, 4'h3);
		on_battery_i = 1'h1;
		ld(4'h7);
		chk({lan, wlan}, 2'h1);
		{on_battery_i, rtc_well_reset_n_i, secure_rtc_reset_n_i} = 3'h0;
		cy(5);
		chk({g3_seen_o, mgmt_bb_reset_o, lan, wlan}, 4'hc);
		{rtc_well_reset_n_i, secure_rtc_reset_n_i} = 2'h3;
		cy(4);
		ld(4'h8);
		chk({mgmt_bb_reset_o, lan}, 2'h1);
		battery_low_n_i = 1'h0;
		cy(4);
		wake_event_i = 1'h1;
		cy(6);
		chk(s3n, 1'h0);
		{battery_low_n_i, s3_req_i, s4_req_i, s5_req_i, mgmt_off_req_i} = 5'h10;
		cy(8);
		chk({s3n, lan, wlan, g3_seen_o}, 4'he);
		wake_event_i = 1'h0;
		cy(4);
	endtask
	// Battery low while running gives one interrupt pulse; C10 entry drives the gate.
	task t_smi;
		seen = 4'h0;
		{battery_low_n_i, c10_entry_i} = 2'h1;
		for (i = 0; i < 8; i = i + 1) begin
			cy(1);
			seen = seen + {3'h0, smi_o};
		end
		chk({seen, deep_idle_gate_n_o}, 5'h2);
		battery_low_n_i = 1'h1;
		cy(4);
	endtask
	// One reset trigger: record drain, global, rails off and ack until platform runs.
	task t_host(input [1:0] kind, input en, input [1:0] exp);
		ack_en = en;
		seen = 4'h0;
		reset_req_i = kind;
		cy(1);
		reset_req_i = 2'h0;
		for (i = 0; i < 20 && prn !== 1'h0; i = i + 1) begin
			cy(1);
			seen[0] = seen[0] | mem_drain_req_o;
		end
		for (i = 0; i < 300 && prn !== 1'h1; i = i + 1) begin
			cy(1);
			seen[3:1] = seen[3:1] | {global_reset_o, ~s3n, pdk};
		end
		chk({seen, prn}, {exp, 3'h3});
	endtask
	// Straight to S5: all wells off, ack policy later, wake only with good battery.
	task t_s5;
		s5_reset_req_i = 1'h1;
		cy(1);
		s5_reset_req_i = 1'h0;
		for (i = 0; i < 40 && s5n !== 1'h0; i = i + 1) cy(1);
		chk({s3n, s4n, s5n, man, lan, wlan, pdk}, 7'h0);
		battery_low_n_i = 1'h0;
		cy(20);
		wake_event_i = 1'h1;
		cy(6);
		chk({pdk, s3n}, 2'h2);
		battery_low_n_i = 1'h1;
		for (i = 0; i < 300 && prn !== 1'h1; i = i + 1) cy(1);
		wake_event_i = 1'h0;
		chk({s3n, prn}, 2'h3);
	endtask
	// Verdict, reached from the main sequence or the watchdog.
	task finish_test;
		$display("checks %0d errors %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// Cut a hang short well past the expected run time.
	initial begin
		#100000;
		n_errors = n_errors + 1;
		finish_test;
	end
	// Reset, then the scenarios; C10 stays requested through the resets.
	initial begin
		cy(2);
		srst_i = 1'h0;
		cy(2);
		t_sleep;
		t_smi;
		t_host(2'h1, 1'h1, 2'h0);
		t_host(2'h2, 1'h1, 2'h1);
		t_host(2'h3, 1'h1, 2'h3);
		t_host(2'h1, 1'h0, 2'h3);
		c10_entry_i = 1'h0;
		t_s5;
		finish_test;
	end
endmodule // sleep_rail_ctl_tb
